// ===== ucb_pkg.sv
// Constants for the serial channel command, buffer and status block
package ucb_pkg;
    // Register byte addresses
    localparam logic [11:0] UCB_A_MCR = 12'h700;
    localparam logic [11:0] UCB_A_MR1 = 12'h704;
    localparam logic [11:0] UCB_A_CR = 12'h708;
    localparam logic [11:0] UCB_A_BUF = 12'h70c;
    localparam logic [11:0] UCB_A_CHG = 12'h710;
    localparam logic [11:0] UCB_A_ACR = 12'h714;
    localparam logic [11:0] UCB_A_ISR = 12'h718;
    localparam logic [11:0] UCB_A_IER = 12'h71c;
    localparam logic [11:0] UCB_A_SR = 12'h720;
    // Field positions
    localparam int UCB_MCR_STOP = 7;
    localparam int UCB_MCR_CSEL = 6;
    localparam int UCB_MR1_RXSEL = 6;
    localparam int UCB_MR1_MDROP = 1;
    localparam int UCB_MR1_LOOP = 0;
    localparam int UCB_ACR_BRG = 7;
    localparam int UCB_ACR_CTS_IRQ_EN_B = 1;
    localparam int UCB_ACR_CTS_IRQ_EN_A = 0;
    localparam int UCB_ISR_COS = 7;
    localparam int UCB_ISR_DBB = 6;
    localparam int UCB_ISR_RXB = 5;
    localparam int UCB_ISR_TXB = 4;
    localparam int UCB_SR_TX_EMPTY_FLAG = 3;
    localparam int UCB_SR_TX_READY_FLAG = 2;
    localparam int UCB_SR_FFULL = 1;
    localparam int UCB_SR_RXRDY = 0;
    // Command codes
    localparam logic [1:0] UCB_CMD_NONE = 2'h0;
    localparam logic [1:0] UCB_CMD_EN = 2'h1;
    localparam logic [1:0] UCB_CMD_DIS = 2'h2;
    localparam logic [3:0] UCB_MISC_RSTBRK = 4'h5;
    // Reset values
    localparam logic [7:0] UCB_ACR_RST = 8'h00;
    localparam logic [7:0] UCB_REG_RST = 8'h00;
    // Receive FIFO depth
    localparam logic [1:0] UCB_FIFO_DEPTH = 2'h3;
    // Clear-to-send filter timing
    localparam int UCB_CLK_MHZ = 100;
    localparam int UCB_CTS_HOLD_US = 25;
    localparam int UCB_CTS_SAMPLE_CYC = UCB_CTS_HOLD_US * UCB_CLK_MHZ;
    localparam logic [1:0] UCB_CTS_START_SAMPLES = 2'h2;
    // One-hot receiver states
    typedef enum logic [3:0] {
        UCB_RX_HUNT = 4'h1,
        UCB_RX_START = 4'h2,
        UCB_RX_DATA = 4'h4,
        UCB_RX_STOP = 4'h8
    } ucb_rx_st_t;
endpackage : ucb_pkg

// ===== ucb_channel.sv
// Serial channel command, receive FIFO, transmit buffer and status
// Operation
// R01: transmitter command field: none, enable, disable, reserved
// R02: transmit enable sets empty and ready flags
// R03: transmit disable clears flags, finishes current character
// R04: receiver command field: none, enable, disable, reserved
// R05: receive enable hunts start bit unless multidrop
// R06: receive disable aborts character, keeps status
// R07: loopback or multidrop keeps receiver running
// R08: software never writes reserved command code
// R09: shift register feeds three-entry receive FIFO
// R10: buffer and status access only while enabled; SR stays readable while the module is stopped
// R11: holding write only while ready, clears ready
// R12: empty shifter takes held character, sets ready
// R13: transmit writes ignored when not ready or disabled
// R14: filtered clear-to-send level change sets change bit
// R15: change register read clears change and summary
// R16: levels follow pins two samples after reset
// R17: aux control bit 7 selects baud set
// R18: enabled change bit sets status bit 7
// R19: interrupt is masked status; reads stay unmasked
// R20: status flags cleared by module reset
// R21: break start or end sets delta break
// R22: mode bit 6 selects ready or full status
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module ucb_channel
    import ucb_pkg::*;
#(
    parameter logic [15:0] DIV_SET1 = 16'h0040,
    parameter logic [15:0] DIV_SET2 = 16'h0020
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    input wire logic cts_pin_a_n,
    input wire logic cts_pin_b_n,
    input wire logic ext_serial_clock,
    output logic irq_q
);

    logic [7:0] mcr_q, mr1_q, acr_q, ier_q, isr_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic xfer, wr, rd, mapped, stopped, hit_lock;
    logic [7:0] wdat, rdat;
    logic loop_md, mdrop, rx_run;

    assign stopped = mcr_q[UCB_MCR_STOP];
    assign loop_md = mr1_q[UCB_MR1_LOOP];
    assign mdrop = mr1_q[UCB_MR1_MDROP];
    assign xfer = psel & penable & ~pready_q;
    assign wdat = pwdata[7:0];
    // Buffer, change, interrupt, command and aux control ports are dead while the module is stopped; MCR, MR1 and SR stay live
    assign hit_lock = (paddr[11:0] == UCB_A_BUF) | (paddr[11:0] == UCB_A_CHG)
        | (paddr[11:0] == UCB_A_ISR) | (paddr[11:0] == UCB_A_ACR)
        | (paddr[11:0] == UCB_A_CR) | (paddr[11:0] == UCB_A_IER); // [R10]
    assign wr = xfer & pwrite & ~(stopped & hit_lock); // [R10]
    assign rd = xfer & ~pwrite & ~(stopped & hit_lock); // [R10]
    assign mapped = (paddr[31:12] == 20'h00000) & (paddr[1:0] == 2'h0)
        & (paddr[11:0] >= UCB_A_MCR) & (paddr[11:0] <= UCB_A_SR);

    logic wr_mcr, wr_mr1, wr_cr, wr_buf, wr_acr, wr_ier, rd_buf, rd_chg;
    assign wr_mcr = wr & (paddr[11:0] == UCB_A_MCR);
    assign wr_mr1 = wr & (paddr[11:0] == UCB_A_MR1);
    assign wr_cr = wr & (paddr[11:0] == UCB_A_CR);
    assign wr_buf = wr & (paddr[11:0] == UCB_A_BUF);
    assign wr_acr = wr & (paddr[11:0] == UCB_A_ACR);
    assign wr_ier = wr & (paddr[11:0] == UCB_A_IER);
    assign rd_buf = rd & (paddr[11:0] == UCB_A_BUF);
    assign rd_chg = rd & (paddr[11:0] == UCB_A_CHG);

    // Command decode; code 11 is left to do nothing
    logic [1:0] txc, rxc;
    logic tx_en_cmd, tx_dis_cmd, rx_en_cmd, rx_dis_cmd, rst_brk;
    assign txc = wr_cr ? wdat[3:2] : UCB_CMD_NONE;
    assign rxc = wr_cr ? wdat[1:0] : UCB_CMD_NONE;
    assign tx_en_cmd = (txc == UCB_CMD_EN); // [R01]
    assign tx_dis_cmd = (txc == UCB_CMD_DIS); // [R01]
    assign rx_en_cmd = (rxc == UCB_CMD_EN); // [R04]
    assign rx_dis_cmd = (rxc == UCB_CMD_DIS); // [R04]
    assign rst_brk = wr_cr & (wdat[7:4] == UCB_MISC_RSTBRK);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mcr_q <= UCB_REG_RST;
            mr1_q <= UCB_REG_RST;
            acr_q <= UCB_ACR_RST; // [R17]
            ier_q <= UCB_REG_RST;
        end
        else
        begin
            if (wr_mcr)
                mcr_q <= wdat;
            if (wr_mr1)
                mr1_q <= wdat;
            if (wr_acr)
                acr_q <= wdat;
            if (wr_ier)
                ier_q <= wdat;
        end
    end

    // 16x bit-rate enable; divider follows the selected baud set
    logic [15:0] div_q, div_ld;
    logic tick;
    assign div_ld = acr_q[UCB_ACR_BRG] ? DIV_SET2 : DIV_SET1; // [R17]
    assign tick = (div_q == 16'h0000);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 16'h0000;
        else
            div_q <= tick ? div_ld - 16'h0001 : div_q - 16'h0001;
    end

    // Transmitter
    logic tx_en_q, tx_rdy_q, tx_emp_q, tx_busy_q;
    logic [7:0] thr_q;
    logic [9:0] tsh_q;
    logic [3:0] tsub_q, tbits_q;
    logic tx_pin_q, tx_load, tx_take, tx_done;
    assign tx_take = wr_buf & tx_en_q & tx_rdy_q; // [R11] [R13]
    assign tx_load = ~tx_busy_q & tx_en_q & ~tx_rdy_q; // [R12]
    assign tx_done = tx_busy_q & tick & (tsub_q == 4'hf)
        & (tbits_q == 4'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_en_q <= 1'b0;
            tx_rdy_q <= 1'b0;
            tx_emp_q <= 1'b0;
            thr_q <= 8'h00;
        end
        else if (tx_dis_cmd)
        begin
            tx_en_q <= 1'b0; // [R03]
            tx_rdy_q <= 1'b0; // [R03]
            tx_emp_q <= 1'b0; // [R03]
        end
        else if (tx_en_cmd & ~tx_en_q)
        begin
            tx_en_q <= 1'b1; // [R02]
            tx_rdy_q <= 1'b1; // [R02]
            tx_emp_q <= 1'b1; // [R02]
        end
        else if (tx_take)
        begin
            thr_q <= wdat;
            tx_rdy_q <= 1'b0; // [R11]
            tx_emp_q <= 1'b0;
        end
        else if (tx_load)
            tx_rdy_q <= 1'b1; // [R12]
        else if (tx_done & tx_rdy_q)
            tx_emp_q <= 1'b1;
    end

    // Shifter runs to the end even after a disable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_busy_q <= 1'b0;
            tsh_q <= 10'h3ff;
            tsub_q <= 4'h0;
            tbits_q <= 4'h0;
            tx_pin_q <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_busy_q <= 1'b1;
            tsh_q <= {1'b1, thr_q, 1'b0}; // [R12]
            tsub_q <= 4'h0;
            tbits_q <= 4'h9;
        end
        else if (tx_busy_q & tick)
        begin
            tx_pin_q <= tsh_q[0]; // [R03]
            tsub_q <= tsub_q + 4'h1;
            if (tsub_q == 4'hf)
            begin
                tsh_q <= {1'b1, tsh_q[9:1]};
                tbits_q <= tbits_q - 4'h1;
                if (tbits_q == 4'h0)
                    tx_busy_q <= 1'b0;
            end
        end
    end

    // Receiver; loopback feeds the transmit line back in
    ucb_rx_st_t rst_q;
    logic rx_en_q, rx_in, brk_q, dbb_ev, pend_q, push, pop;
    logic [3:0] rsub_q, rcnt_q;
    logic [7:0] rsh_q, pend_d_q;
    logic char_ev;
    assign rx_in = loop_md ? tx_pin_q : serial_rx_pin;
    assign rx_run = rx_en_q | loop_md | mdrop; // [R07]
    assign char_ev = rx_run & tick & (rst_q == UCB_RX_STOP)
        & (rsub_q == 4'hf);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_en_q <= 1'b0;
        else if (rx_dis_cmd)
            rx_en_q <= 1'b0; // [R06]
        else if (rx_en_cmd)
            rx_en_q <= 1'b1; // [R05]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_q <= UCB_RX_HUNT;
            rsub_q <= 4'h0;
            rcnt_q <= 4'h0;
            rsh_q <= 8'h00;
        end
        else if (!rx_run | (rx_en_cmd & ~rx_en_q & ~mdrop))
        begin
            rst_q <= UCB_RX_HUNT; // [R05] [R06]
            rsub_q <= 4'h0;
        end
        else if (tick)
        begin
            rsub_q <= rsub_q + 4'h1;
            unique case (rst_q)
                UCB_RX_HUNT:
                begin
                    rsub_q <= 4'h0;
                    if (!rx_in & !brk_q)
                        rst_q <= UCB_RX_START;
                end
                UCB_RX_START:
                    if (rsub_q == 4'h7)
                    begin
                        rsub_q <= 4'h0;
                        rcnt_q <= 4'h0;
                        rst_q <= rx_in ? UCB_RX_HUNT : UCB_RX_DATA;
                    end
                UCB_RX_DATA:
                    if (rsub_q == 4'hf)
                    begin
                        rsh_q <= {rx_in, rsh_q[7:1]}; // [R09]
                        rcnt_q <= rcnt_q + 4'h1;
                        if (rcnt_q == 4'h7)
                            rst_q <= UCB_RX_STOP;
                    end
                UCB_RX_STOP:
                    if (rsub_q == 4'hf)
                        rst_q <= UCB_RX_HUNT;
            endcase
        end
    end

    // Break: null character with a low stop bit, ends on a high line
    logic brk_start, brk_end;
    assign brk_start = char_ev & ~rx_in & (rsh_q == 8'h00) & ~brk_q;
    assign brk_end = brk_q & rx_in & tick & (rst_q == UCB_RX_HUNT);
    assign dbb_ev = brk_start | brk_end; // [R21]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            brk_q <= 1'b0;
        else if (brk_start)
            brk_q <= 1'b1;
        else if (brk_end | !rx_run)
            brk_q <= 1'b0;
    end

    // Pending register pend_d_q holds one waiting character while the FIFO is full
    logic [7:0] fifo_q [0:2];
    logic [1:0] cnt_q, wr_idx;
    assign pop = rd_buf & (cnt_q != 2'h0);
    assign push = pend_q & ((cnt_q != UCB_FIFO_DEPTH) | pop); // [R09]
    assign wr_idx = pop ? cnt_q - 2'h1 : cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 1'b0;
            pend_d_q <= 8'h00;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (char_ev)
                pend_d_q <= rsh_q; // [R09]
            pend_q <= char_ev | (pend_q & ~push);
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_fifo
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    fifo_q[gi] <= 8'h00;
                else if (push & (wr_idx == 2'(gi)))
                    fifo_q[gi] <= pend_d_q; // [R09]
                else if (pop)
                    fifo_q[gi] <= fifo_q[(gi < 2) ? gi + 1 : gi];
            end
        end
    endgenerate

    logic rx_rdy, ffull, rx_status_b;
    assign rx_rdy = (cnt_q != 2'h0);
    assign ffull = (cnt_q == UCB_FIFO_DEPTH);
    assign rx_status_b = mr1_q[UCB_MR1_RXSEL] ? ffull : rx_rdy; // [R22]

    // Clear-to-send sampling; two equal samples accept a new level
    logic [11:0] csmp_q;
    logic xclk_q, csel, smp, crys_smp, started;
    logic [1:0] start_q, cts_pin, cand_q, lvl_q, chg_q, chg_ev;
    assign csel = mcr_q[UCB_MCR_CSEL];
    assign crys_smp = (csmp_q == 12'(UCB_CTS_SAMPLE_CYC - 1));
    assign smp = csel ? (ext_serial_clock & ~xclk_q) : crys_smp; // [R14]
    assign cts_pin = {cts_pin_b_n, cts_pin_a_n};
    assign started = (start_q == UCB_CTS_START_SAMPLES);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            csmp_q <= 12'h000;
            xclk_q <= 1'b0;
            start_q <= 2'h0;
        end
        else
        begin
            csmp_q <= crys_smp ? 12'h000 : csmp_q + 12'h001;
            xclk_q <= ext_serial_clock;
            if (smp & !started)
                start_q <= start_q + 2'h1; // [R16]
        end
    end

    // Levels rest negated until started, so an asserted pin flags a change
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cts
            assign chg_ev[gi] = started & smp & (cts_pin[gi] == cand_q[gi])
                & (cts_pin[gi] != lvl_q[gi]); // [R14] [R16]
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cand_q[gi] <= 1'b1;
                    lvl_q[gi] <= 1'b1;
                    chg_q[gi] <= 1'b0;
                end
                else
                begin
                    if (smp)
                        cand_q[gi] <= cts_pin[gi];
                    if (chg_ev[gi])
                        lvl_q[gi] <= cts_pin[gi]; // [R16]
                    if (chg_ev[gi])
                        chg_q[gi] <= 1'b1; // [R14]
                    else if (rd_chg)
                        chg_q[gi] <= 1'b0; // [R15]
                end
            end
        end
    endgenerate

    // Interrupt status; an event beats a clear in the same cycle
    logic cos_ev;
    logic [7:0] isr_d;
    assign cos_ev = (chg_ev[0] & acr_q[UCB_ACR_CTS_IRQ_EN_A])
        | (chg_ev[1] & acr_q[UCB_ACR_CTS_IRQ_EN_B]); // [R18]
    always_comb
    begin
        isr_d = 8'h00;
        isr_d[UCB_ISR_COS] = cos_ev | (isr_q[UCB_ISR_COS] & ~rd_chg); // [R15]
        isr_d[UCB_ISR_DBB] = dbb_ev | (isr_q[UCB_ISR_DBB] & ~rst_brk); // [R21]
        isr_d[UCB_ISR_RXB] = rx_status_b; // [R22]
        isr_d[UCB_ISR_TXB] = tx_rdy_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            isr_q <= 8'h00; // [R20]
            irq_q <= 1'b0;
        end
        else
        begin
            isr_q <= isr_d;
            irq_q <= |(isr_q & ier_q); // [R19]
        end
    end

    // Read mux; write-only registers read as zero
    logic [7:0] sr_v;
    always_comb
    begin
        sr_v = 8'h00;
        sr_v[UCB_SR_TX_EMPTY_FLAG] = tx_emp_q;
        sr_v[UCB_SR_TX_READY_FLAG] = tx_rdy_q;
        sr_v[UCB_SR_FFULL] = ffull;
        sr_v[UCB_SR_RXRDY] = rx_rdy;
        unique case (paddr[11:0])
            UCB_A_MCR: rdat = mcr_q;
            UCB_A_MR1: rdat = mr1_q;
            UCB_A_BUF: rdat = fifo_q[0]; // [R09]
            UCB_A_CHG: rdat = {2'h0, chg_q, 2'h0, lvl_q}; // [R16]
            UCB_A_ISR: rdat = isr_q; // [R19]
            UCB_A_IER: rdat = ier_q;
            UCB_A_SR: rdat = sr_v;
            default: rdat = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= xfer;
            pslverr_q <= xfer & ~mapped;
            if (rd)
                prdata_q <= {24'h000000, rdat}; // [R10]
            else if (xfer)
                prdata_q <= 32'h00000000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign serial_tx_pin = tx_pin_q;

endmodule : ucb_channel

// ===== ucb_channel_properties.sv
// Bus and line checker for the serial channel block
`timescale 1ns/100ps
module ucb_channel_properties
#(
    parameter logic [15:0] DIV_SET1 = 16'h0040,
    parameter logic [15:0] DIV_SET2 = 16'h0020
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_rx_pin,
    input wire logic serial_tx_pin,
    input wire logic cts_pin_a_n,
    input wire logic cts_pin_b_n,
    input wire logic ext_serial_clock,
    input wire logic irq_q
);
    // Faster set bounds the shortest bit; set 1 only lengthens it
    localparam int MIN_RUN = 16 * DIV_SET2 - 1;
    logic [15:0] run_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 16'hffff;
        else if ($changed(serial_tx_pin))
            run_q <= 16'h0000;
        else if (run_q != 16'hffff)
            run_q <= run_q + 16'h0001;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("pready held for more than one cycle");
    property p_ready_next;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("access phase not answered in the next cycle");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("pready outside an access phase");
    property p_slverr_with_ready;
        pslverr |-> pready;
    endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready)
        else $error("pslverr without pready");
    property p_byte_lane;
        pready && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("read data above the low byte");
    property p_rdata_holds;
        !psel |=> $stable(prdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed with no access");
    property p_reset_outputs;
        $rose(presetn) |-> !irq_q && serial_tx_pin;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("interrupt or line not idle after reset");
    property p_bit_width;
        $changed(serial_tx_pin) |-> run_q >= MIN_RUN;
    endproperty
    a_bit_width: assert property (p_bit_width)
        else $error("line bit shorter than one baud period");
endmodule : ucb_channel_properties

// ===== ucb_term.sv
// Remote serial terminal with clear-to-send lines
`timescale 1ns/100ps
module ucb_term
(
    input wire logic pclk,
    input wire logic serial_tx_pin,
    output logic serial_rx_pin,
    output logic cts_pin_a_n,
    output logic cts_pin_b_n
);
    int bit_cyc = 32;
    logic [7:0] got_q[$];
    initial
    begin
        serial_rx_pin = 1'b1;
        cts_pin_a_n = 1'b1;
        cts_pin_b_n = 1'b1;
    end
    // Ends with an idle bit so back-to-back calls never double-drive
    task send(input logic [7:0] ch, input logic module_stop_bit);
        logic [10:0] f;
        f = {1'b1, module_stop_bit, ch, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            serial_rx_pin <= f[i];
            repeat (bit_cyc) @(posedge pclk);
        end
    endtask : send
    // Mid-bit sampling; a frame without a high stop is dropped
    always
    begin
        logic [7:0] ch;
        @(negedge serial_tx_pin);
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_cyc) @(posedge pclk);
            ch[i] = serial_tx_pin;
        end
        repeat (bit_cyc) @(posedge pclk);
        if (serial_tx_pin === 1'b1)
            got_q.push_back(ch);
    end
endmodule : ucb_term

// ===== tb_uart_channel_cmd_buffer_status.sv
// Self-checking bench for the serial channel block
`timescale 1ns/100ps
module tb_uart_channel_cmd_buffer_status
    import ucb_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_rx_pin;
    logic serial_tx_pin;
    logic cts_pin_a_n;
    logic cts_pin_b_n;
    logic ext_serial_clock;
    logic irq_q;
    logic slv;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    ucb_channel #(.DIV_SET1(16'h0002), .DIV_SET2(16'h0001)) i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_rx_pin(serial_rx_pin),
        .serial_tx_pin(serial_tx_pin), .cts_pin_a_n(cts_pin_a_n),
        .cts_pin_b_n(cts_pin_b_n), .ext_serial_clock(ext_serial_clock),
        .irq_q(irq_q)
    );
    ucb_term i_term
    (
        .pclk(pclk), .serial_tx_pin(serial_tx_pin),
        .serial_rx_pin(serial_rx_pin), .cts_pin_a_n(cts_pin_a_n),
        .cts_pin_b_n(cts_pin_b_n)
    );
    task finish_test;
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d,
        output logic [7:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h00000, a};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(8'hee, 8'h00);
        r = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        apb(a, 1'b1, d, r);
    endtask : wr
    task rd_chk(input logic [11:0] a, input logic [7:0] e,
        input logic [7:0] m = 8'hff);
        logic [7:0] r;
        apb(a, 1'b0, 8'h00, r);
        chk(r & m, e);
    endtask : rd_chk
    // Extra idle time proves no refused character follows
    task wait_tx(input int n);
        int c;
        c = 0;
        while (i_term.got_q.size() < n && c < 3000)
        begin
            @(posedge pclk);
            c++;
        end
        repeat (400) @(posedge pclk);
        chk(8'(i_term.got_q.size()), 8'(n));
    endtask : wait_tx
    initial
    begin
        pclk = 1'b0;
        forever
            #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    initial
    begin
        logic [7:0] r;
        {psel, penable, pwrite, ext_serial_clock} = 4'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(UCB_A_SR, 8'h00);
        rd_chk(UCB_A_CHG, 8'h03);
        apb(12'h7f0, 1'b0, 8'h00, r);
        chk({7'h00, slv}, 8'h01);
        wr(UCB_A_BUF, 8'h99);
        rd_chk(UCB_A_SR, 8'h00);
        for (int k = 0; k < 2; k++)
            wr(UCB_A_CR, 8'h04);
        wr(UCB_A_CR, 8'h00);
        rd_chk(UCB_A_SR, 8'h0c);
        rd_chk(UCB_A_ISR, 8'h10);
        chk({7'h00, irq_q}, 8'h00);
        wr(UCB_A_IER, 8'h10);
        repeat (2) @(posedge pclk);
        chk({7'h00, irq_q}, 8'h01);
        wr(UCB_A_IER, 8'h00);
        wr(UCB_A_BUF, 8'h5a);
        wr(UCB_A_BUF, 8'ha5);
        rd_chk(UCB_A_SR, 8'h00);
        wr(UCB_A_BUF, 8'h3c);
        wait_tx(2);
        chk(i_term.got_q[0], 8'h5a);
        chk(i_term.got_q[1], 8'ha5);
        rd_chk(UCB_A_SR, 8'h0c);
        wr(UCB_A_BUF, 8'h81);
        repeat (100) @(posedge pclk);
        wr(UCB_A_CR, 8'h08);
        rd_chk(UCB_A_SR, 8'h00);
        wait_tx(3);
        chk(i_term.got_q[2], 8'h81);
        wr(UCB_A_MR1, 8'h40);
        wr(UCB_A_CR, 8'h01);
        for (int k = 1; k < 5; k++)
            i_term.send({k[3:0], k[3:0]}, 1'b1);
        rd_chk(UCB_A_SR, 8'h03);
        rd_chk(UCB_A_ISR, 8'h20);
        rd_chk(UCB_A_BUF, 8'h11);
        rd_chk(UCB_A_ISR, 8'h20);
        wr(UCB_A_MR1, 8'h00);
        for (int k = 2; k < 5; k++)
            rd_chk(UCB_A_BUF, {k[3:0], k[3:0]});
        rd_chk(UCB_A_ISR, 8'h00);
        fork
            i_term.send(8'h55, 1'b1);
            begin
                repeat (100) @(posedge pclk);
                wr(UCB_A_CR, 8'h02);
            end
        join
        rd_chk(UCB_A_SR, 8'h00);
        wr(UCB_A_CR, 8'h01);
        i_term.send(8'h00, 1'b0);
        repeat (100) @(posedge pclk);
        rd_chk(UCB_A_ISR, 8'h40, 8'h40);
        wr(UCB_A_CR, 8'h50);
        rd_chk(UCB_A_ISR, 8'h00, 8'h40);
        wr(UCB_A_ACR, 8'h01);
        wr(UCB_A_IER, 8'h80);
        i_term.cts_pin_a_n <= 1'b0;
        repeat (6000) @(posedge pclk);
        rd_chk(UCB_A_ISR, 8'h80, 8'h80);
        chk({7'h00, irq_q}, 8'h01);
        rd_chk(UCB_A_CHG, 8'h12);
        rd_chk(UCB_A_ISR, 8'h00, 8'h80);
        rd_chk(UCB_A_CHG, 8'h02);
        i_term.cts_pin_b_n <= 1'b0;
        repeat (6000) @(posedge pclk);
        rd_chk(UCB_A_CHG, 8'h20);
        rd_chk(UCB_A_ISR, 8'h00, 8'h80);
        wr(UCB_A_CR, 8'h04);
        wr(UCB_A_ACR, 8'h80);
        i_term.bit_cyc = 16;
        wr(UCB_A_BUF, 8'hc3);
        wait_tx(4);
        chk(i_term.got_q[3], 8'hc3);
        wr(UCB_A_MCR, 8'h80);
        rd_chk(UCB_A_ISR, 8'h00);
        wr(UCB_A_BUF, 8'h77);
        wr(UCB_A_MCR, 8'h00);
        rd_chk(UCB_A_SR, 8'h0c, 8'h0c);
        wait_tx(4);
        // Loopback keeps a disabled receiver running; break null goes first
        wr(UCB_A_MR1, 8'h01);
        wr(UCB_A_CR, 8'h02);
        wr(UCB_A_BUF, 8'h6b);
        repeat (300) @(posedge pclk);
        rd_chk(UCB_A_BUF, 8'h00);
        rd_chk(UCB_A_BUF, 8'h6b);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(UCB_A_ISR, 8'h00);
        rd_chk(UCB_A_SR, 8'h00);
        finish_test();
    end
endmodule : tb_uart_channel_cmd_buffer_status
bind ucb_channel ucb_channel_properties
    #(.DIV_SET1(DIV_SET1), .DIV_SET2(DIV_SET2)) i_props
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .cts_pin_a_n(cts_pin_a_n),
    .cts_pin_b_n(cts_pin_b_n), .ext_serial_clock(ext_serial_clock),
    .irq_q(irq_q)
);
